// ===== hdl/ccw_pkg.sv
package ccw_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [4:0] CCW_ADDR_CLK_CTRL_A   = 5'h00;
  localparam logic [4:0] CCW_ADDR_CLK_CTRL_B   = 5'h04;
  localparam logic [4:0] CCW_ADDR_CLK_CTRL_C   = 5'h08;
  localparam logic [4:0] CCW_ADDR_WDT_PROTECT  = 5'h0C;
  localparam logic [4:0] CCW_ADDR_PLL_CTRL     = 5'h10;
  localparam logic [4:0] CCW_ADDR_STATUS       = 5'h14;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CCW_A_SUB_CPU_SEL      = 7;
  localparam int CCW_A_DIV8_SEL         = 6;
  localparam int CCW_A_MAIN_OSC_STOP    = 5;
  localparam int CCW_A_SUB_OSC_ON       = 4;
  localparam int CCW_A_WAIT_PERIPH_GATE = 2;
  localparam int CCW_B_CPU_DIV_HI       = 7;
  localparam int CCW_B_CPU_DIV_LO       = 6;
  localparam int CCW_B_INT_OSC_STOP     = 4;
  localparam int CCW_B_PLL_CPU_SEL      = 1;
  localparam int CCW_C_PERIPH_SRC_SEL   = 1;
  localparam int CCW_W_WDT_SRC_PROTECT  = 7;
  localparam int CCW_P_PLL_RUN          = 7;
  localparam int CCW_S_WAIT             = 3;

  // ----------------------------------------------------------------------
  // timing and divider constants
  // ----------------------------------------------------------------------
  localparam int         CCW_MCLK_HZ     = 20_000_000;
  localparam logic [4:0] CCW_DIV_1       = 5'h01;
  localparam logic [4:0] CCW_DIV_2       = 5'h02;
  localparam logic [4:0] CCW_DIV_4       = 5'h04;
  localparam logic [4:0] CCW_DIV_8       = 5'h08;
  localparam logic [4:0] CCW_DIV_16      = 5'h10;
  localparam logic [3:0] CCW_SUB_DIV_TIMER_CLK_HALF   = 4'hF;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CCW_MODE_HIGH, CCW_MODE_MEDIUM, CCW_MODE_PLL, CCW_MODE_LOW,
    CCW_MODE_LOWPWR, CCW_MODE_IOSC, CCW_MODE_IOSC_LP
  } ccw_mode_t;

  // index into the synchronised oscillator vector
  typedef enum logic [1:0] {
    CCW_SRC_MAIN, CCW_SRC_SUB, CCW_SRC_IOSC, CCW_SRC_PLL
  } ccw_src_t;

  typedef struct packed {
    logic sub_cpu_sel;
    logic div8_sel;
    logic main_osc_stop;
    logic sub_osc_on;
    logic wait_periph_gate;
    logic cpu_div_hi;
    logic cpu_div_lo;
    logic int_osc_stop;
    logic pll_cpu_sel;
    logic periph_src_sel;
    logic wdt_src_protect;
    logic pll_run;
  } ccw_ctl_t;

  typedef struct packed {
    ccw_src_t   src;
    logic [4:0] div;
  } ccw_cfg_t;

  // reset: internal oscillator, divide by 8
  localparam ccw_ctl_t CCW_CTL_RST = '{
    sub_cpu_sel: 1'b0, div8_sel: 1'b1, main_osc_stop: 1'b0,
    sub_osc_on: 1'b0, wait_periph_gate: 1'b0, cpu_div_hi: 1'b0,
    cpu_div_lo: 1'b0, int_osc_stop: 1'b0, pll_cpu_sel: 1'b0,
    periph_src_sel: 1'b1, wdt_src_protect: 1'b0, pll_run: 1'b0};

  localparam ccw_cfg_t CCW_CFG_RST = '{src: CCW_SRC_IOSC, div: 5'h08};

endpackage : ccw_pkg

// ===== hdl/ccw_clock_mode_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the address map.
module ccw_clock_mode_ctrl
  import ccw_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        main_osc_in,
  input  wire logic        sub_osc_in,
  input  wire logic        int_osc_in,
  input  wire logic        pll_clk_in,
  input  wire logic        wait_instr_in,
  input  wire logic        wake_in,
  output logic             cpu_clk_out,
  output logic             wdt_clk_out,
  output logic             periph_clk_undiv_out,
  output logic             sub_div_timer_clk_out,
  output logic             slow_int_osc_clk_out,
  output logic             main_osc_en_out,
  output logic             sub_osc_en_out,
  output logic             int_osc_en_out,
  output logic             pll_en_out,
  output logic      [2:0]  mode_out,
  output logic             wait_state_out
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic ccw_mode_t mode_of(input ccw_ctl_t c);
    if (c.pll_cpu_sel) begin
      mode_of = CCW_MODE_PLL;
    end else if (c.sub_cpu_sel) begin
      mode_of = c.main_osc_stop ? CCW_MODE_LOWPWR : CCW_MODE_LOW;
    end else if (c.periph_src_sel) begin
      mode_of = c.main_osc_stop ? CCW_MODE_IOSC_LP : CCW_MODE_IOSC;
    end else if (!c.div8_sel && !c.cpu_div_hi && !c.cpu_div_lo) begin
      mode_of = CCW_MODE_HIGH;
    end else begin
      mode_of = CCW_MODE_MEDIUM;
    end
  endfunction : mode_of

  function automatic logic [4:0] div_of(input ccw_ctl_t c);
    if (c.div8_sel) begin
      div_of = CCW_DIV_8;
    end else begin
      case ({c.cpu_div_hi, c.cpu_div_lo})
        2'b00:   div_of = CCW_DIV_1;
        2'b01:   div_of = CCW_DIV_2;
        2'b10:   div_of = CCW_DIV_4;
        default: div_of = CCW_DIV_16;
      endcase
    end
  endfunction : div_of

  function automatic ccw_cfg_t cfg_of(input ccw_ctl_t c);
    cfg_of.div = div_of(c);
    case (mode_of(c))
      CCW_MODE_PLL: begin
        cfg_of.src = CCW_SRC_PLL;
      end
      CCW_MODE_LOW, CCW_MODE_LOWPWR: begin
        cfg_of.src = CCW_SRC_SUB;
        cfg_of.div = CCW_DIV_1;
      end
      CCW_MODE_IOSC, CCW_MODE_IOSC_LP: begin
        cfg_of.src = CCW_SRC_IOSC;
      end
      default: begin
        cfg_of.src = CCW_SRC_MAIN;
      end
    endcase
  endfunction : cfg_of

  // ----------------------------------------------------------------------
  // oscillator pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  wire  [3:0] osc_pins = {pll_clk_in, int_osc_in, sub_osc_in, main_osc_in};
  wire  [3:0] osc_edge = sync2_r ^ sync3_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= osc_pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  ccw_ctl_t ctl_r;
  ccw_ctl_t ctl_nxt;
  logic     wait_r;
  logic     waitreq_r;
  logic     [31:0] rdata_r;

  wire        bus_req  = avs_read_in | avs_write_in;
  wire        bus_done = bus_req & ~waitreq_r;
  wire        wr_ok    = bus_done & avs_write_in & avs_byteenable_in[0];
  wire  [7:0] wd       = avs_writedata_in[7:0];
  wire        wr_a     = wr_ok && (avs_address_in == CCW_ADDR_CLK_CTRL_A);
  wire        wr_b     = wr_ok && (avs_address_in == CCW_ADDR_CLK_CTRL_B);
  wire        wr_c     = wr_ok && (avs_address_in == CCW_ADDR_CLK_CTRL_C);
  wire        wr_w     = wr_ok && (avs_address_in == CCW_ADDR_WDT_PROTECT);
  wire        wr_p     = wr_ok && (avs_address_in == CCW_ADDR_PLL_CTRL);
  wire ccw_mode_t mode = mode_of(ctl_r);

  // main stop written while in low-speed mode forces divide-by-8
  wire        lp_entry = wr_a && wd[CCW_A_MAIN_OSC_STOP]
                         && (mode == CCW_MODE_LOW);

  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_a) begin
      ctl_nxt.sub_cpu_sel      = wd[CCW_A_SUB_CPU_SEL];
      ctl_nxt.div8_sel         = wd[CCW_A_DIV8_SEL] | lp_entry;
      ctl_nxt.main_osc_stop    = wd[CCW_A_MAIN_OSC_STOP];
      ctl_nxt.sub_osc_on       = wd[CCW_A_SUB_OSC_ON];
      ctl_nxt.wait_periph_gate = wd[CCW_A_WAIT_PERIPH_GATE];
    end
    if (wr_b) begin
      ctl_nxt.cpu_div_hi       = wd[CCW_B_CPU_DIV_HI];
      ctl_nxt.cpu_div_lo       = wd[CCW_B_CPU_DIV_LO];
      ctl_nxt.int_osc_stop     = wd[CCW_B_INT_OSC_STOP];
      ctl_nxt.pll_cpu_sel      = wd[CCW_B_PLL_CPU_SEL];
    end
    if (wr_c) begin
      ctl_nxt.periph_src_sel   = wd[CCW_C_PERIPH_SRC_SEL];
    end
    if (wr_w) begin
      ctl_nxt.wdt_src_protect  = wd[CCW_W_WDT_SRC_PROTECT];
    end
    if (wr_p) begin
      ctl_nxt.pll_run          = wd[CCW_P_PLL_RUN];
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (avs_address_in)
      CCW_ADDR_CLK_CTRL_A: begin
        rd_byte[CCW_A_SUB_CPU_SEL]      = ctl_r.sub_cpu_sel;
        rd_byte[CCW_A_DIV8_SEL]         = ctl_r.div8_sel;
        rd_byte[CCW_A_MAIN_OSC_STOP]    = ctl_r.main_osc_stop;
        rd_byte[CCW_A_SUB_OSC_ON]       = ctl_r.sub_osc_on;
        rd_byte[CCW_A_WAIT_PERIPH_GATE] = ctl_r.wait_periph_gate;
      end
      CCW_ADDR_CLK_CTRL_B: begin
        rd_byte[CCW_B_CPU_DIV_HI]       = ctl_r.cpu_div_hi;
        rd_byte[CCW_B_CPU_DIV_LO]       = ctl_r.cpu_div_lo;
        rd_byte[CCW_B_INT_OSC_STOP]     = ctl_r.int_osc_stop;
        rd_byte[CCW_B_PLL_CPU_SEL]      = ctl_r.pll_cpu_sel;
      end
      CCW_ADDR_CLK_CTRL_C: begin
        rd_byte[CCW_C_PERIPH_SRC_SEL]   = ctl_r.periph_src_sel;
      end
      CCW_ADDR_WDT_PROTECT: begin
        rd_byte[CCW_W_WDT_SRC_PROTECT]  = ctl_r.wdt_src_protect;
      end
      CCW_ADDR_PLL_CTRL: begin
        rd_byte[CCW_P_PLL_RUN]          = ctl_r.pll_run;
      end
      CCW_ADDR_STATUS: begin
        rd_byte[2:0]                    = mode;
        rd_byte[CCW_S_WAIT]             = wait_r;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // one wait state: request seen, then answered on the next edge
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
      ctl_r     <= CCW_CTL_RST;
    end else begin
      waitreq_r <= ~(bus_req & waitreq_r);
      if (bus_req && waitreq_r) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
      ctl_r <= ctl_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // wait state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_r <= 1'b0;
    end else if (wait_instr_in) begin
      wait_r <= 1'b1;
    end else if (wake_in) begin
      wait_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // CPU clock divider with glitch-free switching
  // ----------------------------------------------------------------------
  ccw_cfg_t   cfg_act_r;
  logic [4:0] cnt_r;
  logic       cpu_clk_r;
  wire ccw_cfg_t cfg_req = cfg_of(ctl_r);
  wire        src_edge = osc_edge[cfg_act_r.src];
  wire        hit      = src_edge && (cnt_r == cfg_act_r.div - 5'h01);
  // new setting is taken only while the output is low
  wire        reload   = ~cpu_clk_r && (cfg_act_r != cfg_req);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_act_r <= CCW_CFG_RST;
      cnt_r     <= 5'h00;
      cpu_clk_r <= 1'b0;
    end else if (reload) begin
      cfg_act_r <= cfg_req;
      cnt_r     <= 5'h00;
    end else if (src_edge) begin
      cnt_r <= hit ? 5'h00 : cnt_r + 5'h01;
      if (hit) begin
        // rising edge withheld in wait, so the gate never cuts a pulse
        cpu_clk_r <= cpu_clk_r ? 1'b0 : ~wait_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // peripheral, timer and watchdog clocks
  // ----------------------------------------------------------------------
  logic       periph_r;
  logic       f1_en_r;
  logic       sub_div_timer_clk_r;
  logic [3:0] sub_div_timer_clk_cnt_r;
  logic       slow_r;
  logic       wdt_r;
  wire ccw_src_t psrc = ctl_r.periph_src_sel ? CCW_SRC_IOSC :
                        (ctl_r.pll_cpu_sel ? CCW_SRC_PLL : CCW_SRC_MAIN);
  wire        f1_en = ~(wait_r & ctl_r.wait_periph_gate)
                      & (mode != CCW_MODE_LOWPWR);
  wire        sub_edge = osc_edge[CCW_SRC_SUB];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      periph_r   <= 1'b0;
      f1_en_r    <= 1'b1;
      sub_div_timer_clk_r     <= 1'b0;
      sub_div_timer_clk_cnt_r <= 4'h0;
      slow_r     <= 1'b0;
      wdt_r      <= 1'b0;
    end else begin
      if (!sync3_r[psrc]) begin
        f1_en_r <= f1_en;
      end
      periph_r <= f1_en_r & sync3_r[psrc];
      if (!ctl_r.sub_osc_on) begin
        sub_div_timer_clk_r     <= 1'b0;
        sub_div_timer_clk_cnt_r <= 4'h0;
      end else if (sub_edge) begin
        sub_div_timer_clk_cnt_r <= sub_div_timer_clk_cnt_r + 4'h1;
        if (sub_div_timer_clk_cnt_r == CCW_SUB_DIV_TIMER_CLK_HALF) begin
          sub_div_timer_clk_r <= ~sub_div_timer_clk_r;
        end
      end
      slow_r <= ~ctl_r.int_osc_stop & sync3_r[CCW_SRC_IOSC];
      wdt_r  <= ctl_r.wdt_src_protect ? sync3_r[CCW_SRC_IOSC]
                                      : cpu_clk_r;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator enables and status
  // ----------------------------------------------------------------------
  logic       main_en_r;
  logic       sub_en_r;
  logic       iosc_en_r;
  logic       pll_en_r;
  logic [2:0] mode_r;

  // enables follow only the control bits, never wait
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_en_r <= 1'b1;
      sub_en_r  <= 1'b0;
      iosc_en_r <= 1'b1;
      pll_en_r  <= 1'b0;
      mode_r    <= 3'h0;
    end else begin
      main_en_r <= ~ctl_r.main_osc_stop;
      sub_en_r  <= ctl_r.sub_osc_on;
      iosc_en_r <= ~ctl_r.int_osc_stop;
      pll_en_r  <= ctl_r.pll_run;
      mode_r    <= mode;
    end
  end

  assign avs_readdata_out      = rdata_r;
  assign avs_waitrequest_out   = waitreq_r;
  assign cpu_clk_out           = cpu_clk_r;
  assign wdt_clk_out           = wdt_r;
  assign periph_clk_undiv_out  = periph_r;
  assign sub_div_timer_clk_out = sub_div_timer_clk_r;
  assign slow_int_osc_clk_out  = slow_r;
  assign main_osc_en_out       = main_en_r;
  assign sub_osc_en_out        = sub_en_r;
  assign int_osc_en_out        = iosc_en_r;
  assign pll_en_out            = pll_en_r;
  assign mode_out              = mode_r;
  assign wait_state_out        = wait_r;

endmodule : ccw_clock_mode_ctrl

// ===== dv/ccw_chk.sv
module ccw_chk
  import ccw_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        int_osc_in,
  input wire logic        wait_instr_in,
  input wire logic        wake_in,
  input wire logic        cpu_clk_out,
  input wire logic        sub_div_timer_clk_out,
  input wire logic        slow_int_osc_clk_out,
  input wire logic        main_osc_en_out,
  input wire logic        sub_osc_en_out,
  input wire logic        int_osc_en_out,
  input wire logic [2:0]  mode_out,
  input wire logic        wait_state_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wait_enter; wait_instr_in |=> wait_state_out; endproperty
  a_wait_enter: assert property (p_wait_enter)
    else $error("wait state not entered after wait instruction");
  property p_wait_cause;
    $rose(wait_state_out) |-> $past(wait_instr_in);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait state entered without wait instruction");
  property p_wait_exit;
    wait_state_out && wake_in && !wait_instr_in |=> !wait_state_out;
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait state not left after wake");
  property p_cpu_held; wait_state_out && !cpu_clk_out |=> !cpu_clk_out;
  endproperty
  a_cpu_held: assert property (p_cpu_held)
    else $error("cpu clock rose during wait");
  property p_cpu_pulse; $rose(cpu_clk_out) |=> cpu_clk_out; endproperty
  a_cpu_pulse: assert property (p_cpu_pulse)
    else $error("cpu clock high phase truncated");
  property p_mode_range; mode_out <= 3'h6; endproperty
  a_mode_range: assert property (p_mode_range)
    else $error("mode code outside the seven modes");
  property p_slow_src;
    $rose(slow_int_osc_clk_out) |-> $past(int_osc_in, 1) ||
      $past(int_osc_in, 2) || $past(int_osc_in, 3) || $past(int_osc_in, 4);
  endproperty
  a_slow_src: assert property (p_slow_src)
    else $error("slow timer clock rose without oscillator");
  property p_sub_div_timer_clk_off;
    !$past(sub_osc_en_out, 1) && !$past(sub_osc_en_out, 2)
      |-> !sub_div_timer_clk_out;
  endproperty
  a_sub_div_timer_clk_off: assert property (p_sub_div_timer_clk_off)
    else $error("sub timer clock active with sub clock off");
  property p_osc_in_wait;
    wait_state_out |-> $stable(main_osc_en_out) &&
      $stable(sub_osc_en_out) && $stable(int_osc_en_out);
  endproperty
  a_osc_in_wait: assert property (p_osc_in_wait)
    else $error("oscillator enable changed during wait");
  property p_bus_ans;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_bus_ans: assert property (p_bus_ans)
    else $error("bus answer not one cycle after request");
  property p_bus_stand;
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h00_0000
      ##1 avs_waitrequest_out;
  endproperty
  a_bus_stand: assert property (p_bus_stand)
    else $error("bus answer longer than one cycle or upper bits set");
endmodule : ccw_chk

bind ccw_clock_mode_ctrl ccw_chk u_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .int_osc_in(int_osc_in),
  .wait_instr_in(wait_instr_in), .wake_in(wake_in),
  .cpu_clk_out(cpu_clk_out), .sub_div_timer_clk_out(sub_div_timer_clk_out),
  .slow_int_osc_clk_out(slow_int_osc_clk_out),
  .main_osc_en_out(main_osc_en_out), .sub_osc_en_out(sub_osc_en_out),
  .int_osc_en_out(int_osc_en_out), .mode_out(mode_out),
  .wait_state_out(wait_state_out));

// ===== dv/testbench.sv
module testbench
  import ccw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 0, rstn_in = 0, rd = 0, wr = 0, wi = 0, wake = 0;
  logic        main_osc = 0, sub_osc = 0, int_osc = 0, pll_clk = 0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, avs_rdata;
  logic [3:0]  be = 4'h0;
  logic        waitreq, cpu_clk, wdt_clk, per_clk, sub_tmr, slow_clk, wait_st;
  logic [2:0]  mode;
  logic        m_en, i_en, pll_en;
  int          err_count = 0, cmp_count = 0;
  int          n_cpu = 0, n_per = 0, n_sub = 0, n_slow = 0, n_wdt = 0;

  always #25 mclk_in = ~mclk_in;
  always #200 main_osc = ~main_osc;
  always #250 sub_osc = ~sub_osc;
  always #300 int_osc = ~int_osc;
  always #150 pll_clk = ~pll_clk;
  always @(posedge cpu_clk) n_cpu++;
  always @(posedge per_clk) n_per++;
  always @(posedge sub_tmr) n_sub++;
  always @(posedge slow_clk) n_slow++;
  always @(posedge wdt_clk) n_wdt++;

  ccw_clock_mode_ctrl dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(avs_rdata),
    .avs_waitrequest_out(waitreq), .main_osc_in(main_osc),
    .sub_osc_in(sub_osc), .int_osc_in(int_osc), .pll_clk_in(pll_clk),
    .wait_instr_in(wi), .wake_in(wake), .cpu_clk_out(cpu_clk),
    .wdt_clk_out(wdt_clk), .periph_clk_undiv_out(per_clk),
    .sub_div_timer_clk_out(sub_tmr), .slow_int_osc_clk_out(slow_clk),
    .main_osc_en_out(m_en), .sub_osc_en_out(), .int_osc_en_out(i_en),
    .pll_en_out(pll_en), .mode_out(mode), .wait_state_out(wait_st));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge mclk_in);
    addr <= a;
    wdata <= {24'h00_0000, d};
    be <= b;
    wr <= w;
    rd <= !w;
    @(posedge mclk_in);
    while (waitreq !== 1'b0) begin
      n++;
      if (n > 50) begin
        chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
        tally_and_finish();
      end
      @(posedge mclk_in);
    end
    rdata = avs_rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string nm, input logic [4:0] a,
                        input logic [31:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(nm, e, rdata);
  endtask : rd_chk

  task automatic step(input logic [4:0] a, input logic [7:0] d,
                      input logic [2:0] m, input int p);
    int  n;
    time t0;
    n = 0;
    bus(1'b1, a, d, 4'hF);
    @(negedge mclk_in);
    while (mode !== m && n < 40) begin
      @(negedge mclk_in);
      n++;
    end
    chk("mode", 32'(m), 32'(mode));
    repeat (2) @(posedge cpu_clk);
    t0 = $time;
    @(posedge cpu_clk);
    chk("cpu period", 32'(p), 32'(($time - t0) / 50));
    $display("step %h %h done", a, d);
  endtask : step

  task automatic t_regs;
    int o0;
    rd_chk("ctrl a", CCW_ADDR_CLK_CTRL_A, 32'h0000_0040);
    rd_chk("ctrl b", CCW_ADDR_CLK_CTRL_B, 32'h0000_0000);
    rd_chk("ctrl c", CCW_ADDR_CLK_CTRL_C, 32'h0000_0002);
    rd_chk("wdt", CCW_ADDR_WDT_PROTECT, 32'h0000_0000);
    rd_chk("status", CCW_ADDR_STATUS, 32'h0000_0005);
    bus(1'b1, CCW_ADDR_CLK_CTRL_B, 8'hFF, 4'h0);
    rd_chk("masked write", CCW_ADDR_CLK_CTRL_B, 32'h0000_0000);
    bus(1'b1, 5'h18, 8'hFF, 4'hF);
    rd_chk("unmapped", 5'h18, 32'h0000_0000);
    bus(1'b1, CCW_ADDR_PLL_CTRL, 8'h80, 4'hF);
    rd_chk("pll ctrl", CCW_ADDR_PLL_CTRL, 32'h0000_0080);
    bus(1'b1, CCW_ADDR_CLK_CTRL_B, 8'h10, 4'hF);
    repeat (4) @(posedge mclk_in);
    o0 = n_slow;
    repeat (40) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("pll enable", 32'h0000_0001, 32'(pll_en));
    chk("int osc enable", 32'h0000_0000, 32'(i_en));
    chk("slow osc stopped", 32'(o0), 32'(n_slow));
    bus(1'b1, CCW_ADDR_CLK_CTRL_B, 8'h00, 4'hF);
    $display("register test done");
  endtask : t_regs

  task automatic t_wait(input logic g, input logic pr);
    int c0, p0, s0, o0, w0;
    bus(1'b1, CCW_ADDR_CLK_CTRL_A, {5'h0A, g, 2'h0}, 4'hF);
    bus(1'b1, CCW_ADDR_WDT_PROTECT, {pr, 7'h00}, 4'hF);
    @(posedge mclk_in);
    wi <= 1'b1;
    @(posedge mclk_in);
    wi <= 1'b0;
    @(negedge mclk_in);
    chk("wait state", 32'h0000_0001, 32'(wait_st));
    rd_chk("status", CCW_ADDR_STATUS, 32'h0000_000D);
    repeat (4) @(posedge mclk_in);
    c0 = n_cpu;
    p0 = n_per;
    s0 = n_sub;
    o0 = n_slow;
    w0 = n_wdt;
    repeat (700) @(posedge mclk_in);
    chk("cpu stopped", 32'(c0), 32'(n_cpu));
    chk("periph stop", 32'(g), 32'(n_per == p0));
    chk("sub timer", 32'h0000_0001, 32'(n_sub > s0));
    chk("slow osc", 32'h0000_0001, 32'(n_slow > o0));
    chk("wdt clock", 32'(pr), 32'(n_wdt > w0));
    @(posedge mclk_in);
    wake <= 1'b1;
    @(posedge mclk_in);
    wake <= 1'b0;
    @(negedge mclk_in);
    chk("wait left", 32'h0000_0000, 32'(wait_st));
    c0 = n_cpu;
    repeat (300) @(posedge mclk_in);
    chk("cpu resumed", 32'h0000_0001, 32'(n_cpu > c0));
    $display("wait test %b %b done", g, pr);
  endtask : t_wait

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #(60_000 * 50);
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_regs();
    step(CCW_ADDR_CLK_CTRL_A, 8'h40, 3'h5, 96);
    step(CCW_ADDR_CLK_CTRL_A, 8'h50, 3'h5, 96);
    step(CCW_ADDR_CLK_CTRL_C, 8'h00, 3'h1, 64);
    step(CCW_ADDR_CLK_CTRL_B, 8'h40, 3'h1, 64);
    step(CCW_ADDR_CLK_CTRL_A, 8'h10, 3'h1, 16);
    step(CCW_ADDR_CLK_CTRL_B, 8'h80, 3'h1, 32);
    step(CCW_ADDR_CLK_CTRL_B, 8'hC0, 3'h1, 128);
    step(CCW_ADDR_CLK_CTRL_B, 8'h00, 3'h0, 8);
    step(CCW_ADDR_CLK_CTRL_B, 8'h02, 3'h2, 6);
    step(CCW_ADDR_CLK_CTRL_B, 8'h00, 3'h0, 8);
    step(CCW_ADDR_CLK_CTRL_A, 8'h90, 3'h3, 10);
    step(CCW_ADDR_CLK_CTRL_A, 8'hB0, 3'h4, 10);
    rd_chk("div8 forced", CCW_ADDR_CLK_CTRL_A, 32'h0000_00F0);
    step(CCW_ADDR_CLK_CTRL_A, 8'hD0, 3'h3, 10);
    step(CCW_ADDR_CLK_CTRL_A, 8'h50, 3'h1, 64);
    step(CCW_ADDR_CLK_CTRL_C, 8'h02, 3'h5, 96);
    step(CCW_ADDR_CLK_CTRL_A, 8'h10, 3'h5, 12);
    step(CCW_ADDR_CLK_CTRL_A, 8'h30, 3'h6, 12);
    chk("main osc off", 32'h0000_0000, 32'(m_en));
    step(CCW_ADDR_CLK_CTRL_A, 8'h50, 3'h5, 96);
    t_wait(1'b0, 1'b0);
    t_wait(1'b1, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
